//--- core/rsb_pkg.sv
// Package for the result and status register bank of the thermal bus command engine.
// Assumes an APB master with 32-bit data and one engine that pulses once per finished transaction.
package rsb_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_NEGOTIATION_COUNT_LOW = 8'h22;
  localparam logic [7:0] IDX_NEGOTIATION_COUNT_HIGH = 8'h23;
  localparam logic [7:0] IDX_AGENT_ALERT_FLAGS = 8'h24;
  localparam logic [7:0] IDX_TRANSACTION_ERROR_FLAGS = 8'h25;
  localparam logic [7:0] IDX_CAPTURED_WRITE_CHECK = 8'h26;
  localparam logic [7:0] IDX_CAPTURED_READ_CHECK = 8'h27;
  localparam logic [7:0] IDX_CAPTURED_ABORT_CHECK = 8'h28;
  localparam logic [7:0] IDX_COMPUTED_WRITE_CHECK = 8'h29;
  localparam logic [7:0] IDX_RESPONSE_BYTE_ONE = 8'h2a;
  localparam logic [7:0] IDX_RESPONSE_BYTE_TWO = 8'h2b;
  localparam logic [7:0] IDX_RESPONSE_BYTE_THREE = 8'h2c;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h40;
  localparam logic [7:0] IDX_EVENT_MASK = 8'h41;

  // ----------------------------------------------------------------
  // Field layout, reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [2:0] HIST_RESET = 3'h0;
  localparam int HIST_DEPTH = 3;
  localparam int EVT_DONE_BIT = 0;
  localparam int EVT_ERROR_BIT = 1;
  localparam int EVT_ALERT_BIT = 2;

  // Six transaction flags, bit 5 down to bit 0
  typedef struct packed {
    logic warning;
    logic completion_code_fail_flag;
    logic zero_write_check_flag;
    logic abort_write_check_flag;
    logic bad_read_check_flag;
    logic bad_write_check_flag;
  } rsb_flags_s;

  // Everything the engine hands over when a transaction completes
  typedef struct packed {
    logic agent;
    logic [11:0] timing_negotiation;
    rsb_flags_s flags;
    logic [7:0] captured_write_check;
    logic [7:0] captured_read_check;
    logic [7:0] captured_abort_check;
    logic [7:0] computed_write_check;
    logic [7:0] response_byte_one;
    logic [7:0] response_byte_two;
    logic [7:0] response_byte_three;
  } rsb_result_s;

  // APB request as seen by the slave
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rsb_apb_req_s;

endpackage : rsb_pkg

//--- core/rsb_result_status_regs.sv
// Read-only result and status register bank with an APB slave and a masked event interrupt.
// Assumes the command engine presents a full result and a one-cycle done pulse per transaction.
`timescale 1ns/1ps
`default_nettype none

module rsb_result_status_regs (
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic result_done,
  input wire rsb_pkg::rsb_result_s result,
  output logic irq
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] negotiation_count_low;
  logic [7:0] negotiation_count_high;
  logic [7:0] agent_alert_flags;
  logic [7:0] transaction_error_flags;
  logic [7:0] captured_write_check;
  logic [7:0] captured_read_check;
  logic [7:0] captured_abort_check;
  logic [7:0] computed_write_check;
  logic [7:0] response_byte_one;
  logic [7:0] response_byte_two;
  logic [7:0] response_byte_three;
  logic [2:0] check_history [2];
  logic [2:0] event_status;
  logic [2:0] event_mask;
  rsb_pkg::rsb_apb_req_s req;
  logic bad_check;
  logic [1:0] next_alert;
  logic [2:0] event_set;
  logic [7:0] access_index;
  logic access_mapped;
  logic setup_phase;
  logic write_commit;
  logic [1:0] clean_run [2];

  // Word index from a byte address, or an out-of-range marker when misaligned or when address bit 10 or 11 is set
  function automatic logic [7:0] word_index(input logic [11:0] addr);
    word_index = (addr[1:0] == 2'h0 && addr[11:10] == 2'h0) ? addr[9:2] : 8'hff;
  endfunction : word_index

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  assign access_index = word_index(req.paddr);
  assign access_mapped = (access_index >= rsb_pkg::IDX_NEGOTIATION_COUNT_LOW &&
                          access_index <= rsb_pkg::IDX_RESPONSE_BYTE_THREE) ||
                         access_index == rsb_pkg::IDX_EVENT_STATUS ||
                         access_index == rsb_pkg::IDX_EVENT_MASK;
  assign setup_phase = req.psel && !req.penable;
  assign write_commit = req.psel && req.penable && pready && req.pwrite;

  // A bad check of either direction counts as an invalid check sequence
  assign bad_check = result.flags.bad_read_check_flag || result.flags.bad_write_check_flag;

  // ----------------------------------------------------------------
  // Captured result registers
  // ----------------------------------------------------------------
  // Only the done pulse loads these; bus writes never reach them
  always_ff @(posedge clock) begin
    if (rst) begin
      negotiation_count_low <= rsb_pkg::REG_RESET;
      negotiation_count_high <= rsb_pkg::REG_RESET;
      transaction_error_flags <= rsb_pkg::REG_RESET;
      captured_write_check <= rsb_pkg::REG_RESET;
      captured_read_check <= rsb_pkg::REG_RESET;
      captured_abort_check <= rsb_pkg::REG_RESET;
      computed_write_check <= rsb_pkg::REG_RESET;
      response_byte_one <= rsb_pkg::REG_RESET;
      response_byte_two <= rsb_pkg::REG_RESET;
      response_byte_three <= rsb_pkg::REG_RESET;
    end else if (result_done) begin
      negotiation_count_low <= result.timing_negotiation[7:0];
      negotiation_count_high <= {4'h0, result.timing_negotiation[11:8]};
      transaction_error_flags <= {2'h0, result.flags};
      captured_write_check <= result.captured_write_check;
      captured_read_check <= result.captured_read_check;
      captured_abort_check <= result.captured_abort_check;
      computed_write_check <= result.computed_write_check;
      response_byte_one <= result.response_byte_one;
      response_byte_two <= result.response_byte_two;
      response_byte_three <= result.response_byte_three;
    end
  end

  // ----------------------------------------------------------------
  // Per-agent check history
  // ----------------------------------------------------------------
  // Three-deep window per agent; the alert drops after three clean transactions
  always_ff @(posedge clock) begin
    if (rst) begin
      check_history[0] <= rsb_pkg::HIST_RESET;
      check_history[1] <= rsb_pkg::HIST_RESET;
    end else if (result_done) begin
      check_history[result.agent] <= {check_history[result.agent][1:0], bad_check};
    end
  end

  // Alert is the OR of the window, held as a flop so it reads stable
  always_comb begin
    next_alert = {|check_history[1], |check_history[0]};
    if (result_done) begin
      next_alert[result.agent] = |{check_history[result.agent][1:0], bad_check};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      agent_alert_flags <= rsb_pkg::REG_RESET;
    end else begin
      agent_alert_flags <= {6'h00, next_alert};
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt
  // ----------------------------------------------------------------
  // Events: done, any flag raised, an alert bit rising
  assign event_set[rsb_pkg::EVT_DONE_BIT] = result_done;
  assign event_set[rsb_pkg::EVT_ERROR_BIT] = result_done && (|result.flags);
  assign event_set[rsb_pkg::EVT_ALERT_BIT] = |(next_alert & ~agent_alert_flags[1:0]);

  // Write-one-to-clear; a new event in the same cycle wins over the clear
  always_ff @(posedge clock) begin
    if (rst) begin
      event_status <= rsb_pkg::EVT_RESET;
    end else if (write_commit && access_index == rsb_pkg::IDX_EVENT_STATUS) begin
      event_status <= (event_status & ~req.pwdata[2:0]) | event_set;
    end else begin
      event_status <= event_status | event_set;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      event_mask <= rsb_pkg::EVT_RESET;
    end else if (write_commit && access_index == rsb_pkg::IDX_EVENT_MASK) begin
      event_mask <= req.pwdata[2:0];
    end
  end

  // Registered so the output is glitch free; lags status by one cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(event_status & event_mask);
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait-free access: ready rises for the first access cycle only
  always_ff @(posedge clock) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup_phase;
      pslverr <= setup_phase && !access_mapped;
    end
  end

  // Read data captured at the setup edge; bank writes fall through silently
  always_ff @(posedge clock) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !req.pwrite) begin
      case (access_index)
        rsb_pkg::IDX_NEGOTIATION_COUNT_LOW: prdata <= {24'h00_0000, negotiation_count_low};
        rsb_pkg::IDX_NEGOTIATION_COUNT_HIGH: prdata <= {24'h00_0000, negotiation_count_high};
        rsb_pkg::IDX_AGENT_ALERT_FLAGS: prdata <= {24'h00_0000, agent_alert_flags};
        rsb_pkg::IDX_TRANSACTION_ERROR_FLAGS: prdata <= {24'h00_0000, transaction_error_flags};
        rsb_pkg::IDX_CAPTURED_WRITE_CHECK: prdata <= {24'h00_0000, captured_write_check};
        rsb_pkg::IDX_CAPTURED_READ_CHECK: prdata <= {24'h00_0000, captured_read_check};
        rsb_pkg::IDX_CAPTURED_ABORT_CHECK: prdata <= {24'h00_0000, captured_abort_check};
        rsb_pkg::IDX_COMPUTED_WRITE_CHECK: prdata <= {24'h00_0000, computed_write_check};
        rsb_pkg::IDX_RESPONSE_BYTE_ONE: prdata <= {24'h00_0000, response_byte_one};
        rsb_pkg::IDX_RESPONSE_BYTE_TWO: prdata <= {24'h00_0000, response_byte_two};
        rsb_pkg::IDX_RESPONSE_BYTE_THREE: prdata <= {24'h00_0000, response_byte_three};
        rsb_pkg::IDX_EVENT_STATUS: prdata <= {29'h0000_0000, event_status};
        rsb_pkg::IDX_EVENT_MASK: prdata <= {29'h0000_0000, event_mask};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Assertion helpers
  // ----------------------------------------------------------------
  // Clean transactions per agent since its last bad check, saturating at the window depth.
  // Kept apart from the shift history so the alert assertion does not reuse the logic it checks.
  localparam logic [1:0] CLEAN_FULL = 2'(rsb_pkg::HIST_DEPTH);

  always_ff @(posedge clock) begin
    if (rst) begin
      clean_run[0] <= CLEAN_FULL;
      clean_run[1] <= CLEAN_FULL;
    end else if (result_done) begin
      if (bad_check) begin
        clean_run[result.agent] <= 2'h0;
      end else if (clean_run[result.agent] != CLEAN_FULL) begin
        clean_run[result.agent] <= clean_run[result.agent] + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_COUNT_HIGH: assert property (result_done |=>
    negotiation_count_high == {4'h0, $past(result.timing_negotiation[11:8])})
    else $error("count high nibble not captured");

  AST_COUNT_LOW: assert property (result_done |=>
    negotiation_count_low == $past(result.timing_negotiation[7:0]))
    else $error("count low byte not captured");

  AST_ALERT_SET: assert property (result_done && bad_check && result.agent == 1'b0 |=>
    agent_alert_flags[0] && agent_alert_flags[7:2] == 6'h00)
    else $error("alert not raised after bad check");

  AST_ALERT_CLEAR: assert property ((result_done && !bad_check && result.agent == 1'b1) [*3] |=>
    !agent_alert_flags[1])
    else $error("alert stuck after three clean transactions");

  AST_ERROR_FLAGS: assert property (result_done |=>
    transaction_error_flags == {2'h0, $past(result.flags)})
    else $error("error flags not captured");

  AST_CHECK_BYTES: assert property (result_done |=>
    captured_write_check == $past(result.captured_write_check) &&
    captured_read_check == $past(result.captured_read_check))
    else $error("check bytes not captured");

  AST_ABORT_COMPUTED: assert property (result_done |=>
    captured_abort_check == $past(result.captured_abort_check) &&
    computed_write_check == $past(result.computed_write_check))
    else $error("abort or computed check not captured");

  AST_RESPONSE: assert property (result_done |=>
    response_byte_three == $past(result.response_byte_three) &&
    response_byte_one == $past(result.response_byte_one))
    else $error("response bytes not captured");

  AST_READ_ONLY: assert property (write_commit && !result_done |=>
    $stable(captured_write_check) && $stable(transaction_error_flags) && $stable(response_byte_two))
    else $error("bus write changed a bank register");

  AST_HOLD: assert property (!result_done |=> $stable(captured_read_check))
    else $error("capture changed without a transaction");

  AST_RESET_CLEAR: assert property (disable iff (1'b0) rst |=>
    agent_alert_flags == 8'h00 && transaction_error_flags == 8'h00 && response_byte_one == 8'h00)
    else $error("reset did not clear the bank");

  AST_READY: assert property (setup_phase |=> pready ##1 !pready)
    else $error("ready not a single access cycle");

  AST_IRQ: assert property (##1 irq == |($past(event_status) & $past(event_mask)))
    else $error("interrupt does not follow masked status");

  // ----------------------------------------------------------------
  // Window, reserved bits, read-back and event checks
  // ----------------------------------------------------------------
  // Alert bits against the independent clean-run counters, in every cycle
  AST_ALERT_WINDOW: assert property (
    agent_alert_flags[1:0] == {clean_run[1] != CLEAN_FULL, clean_run[0] != CLEAN_FULL})
    else $error("alert does not match the three-transaction window");

  // Reserved bits can only be zero; a stray concatenation would show here
  AST_ALERT_RESERVED: assert property (agent_alert_flags[7:2] == 6'h00)
    else $error("reserved alert bits set");

  AST_FLAG_RESERVED: assert property (transaction_error_flags[7:6] == 2'h0)
    else $error("reserved flag bits set");

  AST_HIGH_NIBBLE: assert property (negotiation_count_high[7:4] == 4'h0)
    else $error("reserved count bits set");

  AST_RESPONSE_TWO: assert property (result_done |=>
    response_byte_two == $past(result.response_byte_two))
    else $error("second response byte not captured");

  // Read data is latched at the setup edge, so it shows the register as it stood there.
  // These tie the bus view to the storage, which the capture checks alone would miss.
  AST_READ_LOW: assert property (
    setup_phase && !req.pwrite && access_index == rsb_pkg::IDX_NEGOTIATION_COUNT_LOW |=>
    prdata == {24'h00_0000, $past(negotiation_count_low)})
    else $error("count low byte read back wrong");

  AST_READ_HIGH: assert property (
    setup_phase && !req.pwrite && access_index == rsb_pkg::IDX_NEGOTIATION_COUNT_HIGH |=>
    prdata[31:4] == 28'h000_0000 && prdata[3:0] == $past(negotiation_count_high[3:0]))
    else $error("count high nibble read back wrong");

  AST_READ_ALERT: assert property (
    setup_phase && !req.pwrite && access_index == rsb_pkg::IDX_AGENT_ALERT_FLAGS |=>
    prdata == {24'h00_0000, $past(agent_alert_flags)})
    else $error("alert flags read back wrong");

  AST_READ_FLAGS: assert property (
    setup_phase && !req.pwrite && access_index == rsb_pkg::IDX_TRANSACTION_ERROR_FLAGS |=>
    prdata == {24'h00_0000, $past(transaction_error_flags)})
    else $error("error flags read back wrong");

  AST_READ_CHECK: assert property (
    setup_phase && !req.pwrite && access_index == rsb_pkg::IDX_CAPTURED_WRITE_CHECK |=>
    prdata == {24'h00_0000, $past(captured_write_check)})
    else $error("captured write check read back wrong");

  AST_READ_COMPUTED: assert property (
    setup_phase && !req.pwrite && access_index == rsb_pkg::IDX_COMPUTED_WRITE_CHECK |=>
    prdata == {24'h00_0000, $past(computed_write_check)})
    else $error("computed write check read back wrong");

  AST_READ_RESPONSE: assert property (
    setup_phase && !req.pwrite && access_index == rsb_pkg::IDX_RESPONSE_BYTE_THREE |=>
    prdata == {24'h00_0000, $past(response_byte_three)})
    else $error("third response byte read back wrong");

  // Error response only for holes in the map; read-only bank writes answer okay
  AST_UNMAPPED: assert property (setup_phase |=> pslverr == !$past(access_mapped))
    else $error("slave error does not follow the address map");

  AST_READY_SOURCE: assert property (pready |-> $past(setup_phase))
    else $error("ready without a preceding setup cycle");

  // A new event wins over a clear in the same cycle, so a done pulse always lands
  AST_DONE_EVENT: assert property (result_done |=> event_status[rsb_pkg::EVT_DONE_BIT])
    else $error("done event lost");

  AST_STATUS_CLEAR: assert property (write_commit && access_index == rsb_pkg::IDX_EVENT_STATUS &&
    event_set == 3'h0 |=> (event_status & $past(req.pwdata[2:0])) == 3'h0)
    else $error("status bit survived a write of one");

  AST_MASK_WRITE: assert property (write_commit && access_index == rsb_pkg::IDX_EVENT_MASK |=>
    event_mask == $past(req.pwdata[2:0]))
    else $error("mask write not taken");

  COV_BAD_CHECK: cover property (result_done && bad_check);
  COV_READ_FLAGS: cover property (pready && !pwrite && access_index == rsb_pkg::IDX_TRANSACTION_ERROR_FLAGS);
  COV_IRQ: cover property (irq);
  COV_ALERT_DROP: cover property (agent_alert_flags[1] ##1 !agent_alert_flags[1]);
  COV_SET_CLEAR: cover property (write_commit && access_index == rsb_pkg::IDX_EVENT_STATUS && |event_set);

endmodule : rsb_result_status_regs

`default_nettype wire

//--- verif/rsb_engine_model.sv
// Command engine stand-in that hands one result to the bank per send call.
// Assumes the bench calls send between clock edges; the task aligns itself to the rising edge.
`timescale 1ns/1ps
`default_nettype none

module rsb_engine_model (
  input wire logic clock,
  output logic result_done,
  output var rsb_pkg::rsb_result_s result
);
  // ----------------------------------------------------------------
  // Idle state
  // ----------------------------------------------------------------
  initial begin
    result_done = 1'b0;
    result = '0;
  end

  // One-cycle done pulse; afterwards the bus shows the inverse so a stale sample cannot match
  task automatic send(input rsb_pkg::rsb_result_s r);
    @(posedge clock);
    result_done <= 1'b1;
    result <= r;
    @(posedge clock);
    result_done <= 1'b0;
    result <= ~r;
  endtask : send

  // Same result on three consecutive edges, for the back-to-back case
  task automatic burst(input rsb_pkg::rsb_result_s r);
    @(posedge clock);
    result_done <= 1'b1;
    result <= r;
    repeat (3) @(posedge clock);
    result_done <= 1'b0;
    result <= ~r;
  endtask : burst
endmodule : rsb_engine_model
`default_nettype wire

//--- verif/testbench.sv
// Self-checking bench for the result and status bank: APB tasks plus an engine model.
// Assumes the slave answers with pready within 20 access cycles.
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic clock;
  logic rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic result_done;
  rsb_pkg::rsb_result_s result;
  logic [31:0] d;
  logic e;
  int n_errors = 0;
  int tests_run = 0;
  int k;

  rsb_result_status_regs dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .result_done(result_done), .result(result), .irq(irq));
  rsb_engine_model eng_u (.clock(clock), .result_done(result_done), .result(result));

  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [11:0] ba(input logic [7:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ba

  // Result with distinct bytes base, base+1 .. base+6 in field order
  function automatic rsb_pkg::rsb_result_s mk(input logic ag, input logic [11:0] cnt, input logic [5:0] fl,
                                              input logic [7:0] b);
    rsb_pkg::rsb_result_s r;
    r = {ag, cnt, fl, b, b + 8'h01, b + 8'h02, b + 8'h03, b + 8'h04, b + 8'h05, b + 8'h06};
    return r;
  endfunction : mk

  // Request held from setup until the edge that samples pready high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      n_errors++;
      print_verdict();
    end else begin
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(d, exp);
    check({31'h0, e}, 32'h0);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
    check({31'h0, e}, 32'h0);
  endtask : wr

  // Irq lags the status and mask by one cycle, so two edges settle it
  task automatic irq_is(input logic exp);
    repeat (2) @(posedge clock);
    check({31'h0, irq}, {31'h0, exp});
  endtask : irq_is

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (k = 8'h22; k <= 8'h2c; k++) rd(ba(k[7:0]), 32'h0);
    rd(ba(rsb_pkg::IDX_EVENT_MASK), 32'h0);
    irq_is(1'b0);
    $display("test reset_values done");

    // Count 0xabc splits over two registers; upper nibble of the high one stays zero
    eng_u.send(mk(1'b0, 12'habc, 6'h21, 8'h50));
    rd(ba(rsb_pkg::IDX_NEGOTIATION_COUNT_LOW), 32'hbc);
    rd(ba(rsb_pkg::IDX_NEGOTIATION_COUNT_HIGH), 32'h0a);
    rd(ba(rsb_pkg::IDX_AGENT_ALERT_FLAGS), 32'h01);
    rd(ba(rsb_pkg::IDX_TRANSACTION_ERROR_FLAGS), 32'h21);
    rd(ba(rsb_pkg::IDX_CAPTURED_WRITE_CHECK), 32'h50);
    rd(ba(rsb_pkg::IDX_CAPTURED_READ_CHECK), 32'h51);
    rd(ba(rsb_pkg::IDX_CAPTURED_ABORT_CHECK), 32'h52);
    rd(ba(rsb_pkg::IDX_COMPUTED_WRITE_CHECK), 32'h53);
    for (k = 0; k < 3; k++) rd(ba(8'h2a + k[7:0]), 32'h54 + k);
    rd(ba(rsb_pkg::IDX_EVENT_STATUS), 32'h07);
    $display("test capture done");

    // Writes to the bank are accepted but change nothing; bad addresses are refused
    for (k = 8'h22; k <= 8'h2c; k++) wr(ba(k[7:0]), 32'hffffffff);
    rd(ba(rsb_pkg::IDX_CAPTURED_WRITE_CHECK), 32'h50);
    rd(ba(rsb_pkg::IDX_RESPONSE_BYTE_THREE), 32'h56);
    xfer(1'b0, ba(8'h30), 32'h0);
    check(d, 32'h0);
    check({31'h0, e}, 32'h1);
    xfer(1'b1, 12'h099, 32'h0);
    check({31'h0, e}, 32'h1);
    $display("test read_only done");

    // Interrupt masked, unmasked, then cleared by writing ones
    irq_is(1'b0);
    wr(ba(rsb_pkg::IDX_EVENT_MASK), 32'h01);
    irq_is(1'b1);
    wr(ba(rsb_pkg::IDX_EVENT_STATUS), 32'h07);
    irq_is(1'b0);
    rd(ba(rsb_pkg::IDX_EVENT_STATUS), 32'h0);
    rd(ba(rsb_pkg::IDX_EVENT_MASK), 32'h01);
    $display("test interrupt done");

    // Agent 1 goes bad; agent 0 needs three clean transactions to drop its alert
    eng_u.send(mk(1'b1, 12'h123, 6'h02, 8'h60));
    rd(ba(rsb_pkg::IDX_AGENT_ALERT_FLAGS), 32'h03);
    wr(ba(rsb_pkg::IDX_EVENT_STATUS), 32'h07);
    for (k = 0; k < 3; k++) begin
      eng_u.send(mk(1'b0, 12'h000, 6'h00, 8'h00));
      rd(ba(rsb_pkg::IDX_AGENT_ALERT_FLAGS), (k < 2) ? 32'h03 : 32'h02);
    end
    rd(ba(rsb_pkg::IDX_TRANSACTION_ERROR_FLAGS), 32'h0);
    rd(ba(rsb_pkg::IDX_EVENT_STATUS), 32'h01);
    // Agent 1 drops its alert after three back-to-back clean results
    eng_u.burst(mk(1'b1, 12'h000, 6'h00, 8'h00));
    rd(ba(rsb_pkg::IDX_AGENT_ALERT_FLAGS), 32'h00);
    $display("test alert_history done");

    // Reset again in mid-run
    rst <= 1'b1;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(ba(rsb_pkg::IDX_AGENT_ALERT_FLAGS), 32'h0);
    rd(ba(rsb_pkg::IDX_COMPUTED_WRITE_CHECK), 32'h0);
    rd(ba(rsb_pkg::IDX_EVENT_MASK), 32'h0);
    irq_is(1'b0);
    $display("test second_reset done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
